// ### dv/ppxb_crossbar_asserts.sv
// checker: port-level properties of the priority pin crossbar
module ppxb_crossbar_asserts
    import ppxb_pkg::*;
(
    // clock, reset and configuration
    input wire logic                        clk_sys_in,
    input wire logic                        rstn_in,
    input wire logic [7:0]                  periph_route_select_a_in,
    input wire logic [7:0]                  periph_route_select_b_in,
    input wire logic [1:0]                  spi_slave_select_mode_in,
    input wire logic [ppxb_pkg::PIN_N-1:0]  pin_input_mode_in,
    input wire logic [ppxb_pkg::PIN_N-1:0]  pin_output_mode_in,
    input wire logic [ppxb_pkg::XBAR_N-1:0] pin_skip_mask_in,
    // pad side and status
    input wire logic [ppxb_pkg::PIN_N-1:0]  pad_in,
    input wire logic [ppxb_pkg::PIN_N-1:0]  pad_out,
    input wire logic [ppxb_pkg::PIN_N-1:0]  pad_oe_out,
    input wire logic [ppxb_pkg::PIN_N-1:0]  pad_pullup_out,
    input wire logic [ppxb_pkg::PIN_N-1:0]  pad_rx_en_out,
    input wire logic [ppxb_pkg::PIN_N-1:0]  port_read_out,
    input wire logic [ppxb_pkg::PIN_N-1:0]  pin_assigned_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    wire xbar_en = periph_route_select_b_in[SELB_XBAR_EN]; // global enable
    // spi alone, nothing skipped: placement starts at pin 0
    sequence s_spi_only;
        periph_route_select_a_in == 8'h02 &&
        periph_route_select_b_in == 8'h40 && pin_skip_mask_in == '0;
    endsequence
    // four calm digital cycles out of reset, so the sync chain is full
    sequence s_digital_run;
        (rstn_in && pin_input_mode_in == '1)[*4];
    endsequence
    a_off_no_drive: assert property (!xbar_en |=> pad_oe_out == '0)
        else $error("driver on while crossbar off");
    a_off_no_owner: assert property (!xbar_en |=> pin_assigned_out == '0)
        else $error("pin owned while crossbar off");
    a_analog_cell: assert property (1'b1 |=> ((pad_oe_out |
        pad_pullup_out | pad_rx_en_out) & ~$past(pin_input_mode_in)) == '0)
        else $error("analog pin cell not quiet");
    a_uart_fixed: assert property ((xbar_en &&
        periph_route_select_a_in[SELA_UART]) |=> pin_assigned_out[5:4] == 2'h3)
        else $error("uart pins not owned");
    a_p20_never: assert property (pin_assigned_out[16] == 1'b0)
        else $error("last pin owned");
    a_od_no_high: assert property (1'b1 |=> (pad_oe_out & pad_out &
        ~$past(pin_output_mode_in)) == '0)
        else $error("open drain pin driven high");
    a_pullup_low: assert property ((pad_pullup_out & pad_oe_out & ~pad_out)
        == '0) else $error("pull-up on while driving low");
    a_wpud_off: assert property (periph_route_select_b_in[SELB_WPUD] |=>
        pad_pullup_out == '0) else $error("pull-up on while disabled");
    a_spi_four: assert property (s_spi_only ##0
        spi_slave_select_mode_in[1] |=> pin_assigned_out == 17'h0000F)
        else $error("spi four wire pins wrong");
    a_read_delay: assert property (s_digital_run |->
        port_read_out == $past(pad_in, 3)) else $error("port read late");
endmodule // ppxb_crossbar_asserts

bind ppxb_crossbar ppxb_crossbar_asserts ppxb_crossbar_asserts_i (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .periph_route_select_a_in(periph_route_select_a_in),
    .periph_route_select_b_in(periph_route_select_b_in),
    .spi_slave_select_mode_in(spi_slave_select_mode_in),
    .pin_input_mode_in(pin_input_mode_in),
    .pin_output_mode_in(pin_output_mode_in),
    .pin_skip_mask_in(pin_skip_mask_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_out(pad_oe_out),
    .pad_pullup_out(pad_pullup_out), .pad_rx_en_out(pad_rx_en_out),
    .port_read_out(port_read_out), .pin_assigned_out(pin_assigned_out));

// ### dv/ppxb_crossbar_tb.sv
// testbench: placement, enable, cell mode and pull-up checks
module ppxb_crossbar_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ppxb_pkg::*;
    logic             clk_sys_in, rstn_in;
    logic [7:0]       sel_a, sel_b;        // route selects
    logic [1:0]       mode;                // spi slave select mode
    logic [XBAR_N-1:0] skip;
    logic [PIN_N-1:0] in_mode, out_mode, latch, pad_lvl, pad_o, pad_oe;
    logic [PIN_N-1:0] pad_pu, rx_en, rd, owned;
    logic [RES_N-1:0] p_out, p_oe, p_in;
    int               failures, samples_checked, cycles;

    ppxb_crossbar ppxb_crossbar_i (.clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in), .periph_route_select_a_in(sel_a),
        .periph_route_select_b_in(sel_b), .spi_slave_select_mode_in(mode),
        .pin_input_mode_in(in_mode), .pin_output_mode_in(out_mode),
        .pin_skip_mask_in(skip), .port_latch_in(latch),
        .periph_out_in(p_out), .periph_oe_in(p_oe), .periph_in_out(p_in),
        .pad_in(pad_lvl), .pad_out(pad_o), .pad_oe_out(pad_oe),
        .pad_pullup_out(pad_pu), .pad_rx_en_out(rx_en),
        .port_read_out(rd), .pin_assigned_out(owned));
    ppxb_pad_model ppxb_pad_model_i (.clk_sys_in(clk_sys_in),
        .pad_out(pad_o), .pad_oe_out(pad_oe), .pad_pullup_out(pad_pu),
        .pad_lvl_out(pad_lvl));

    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            finish_test();
        end
    end

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp,
                       input string msg);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s %h not %h", $time, msg, seen, exp);
        end
    endtask
    // outputs follow config one edge later; one more for margin
    task automatic settle();
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic cfg(input logic [7:0] a, input logic [7:0] b,
                       input logic [1:0] m, input logic [15:0] sk);
        @(posedge clk_sys_in);
        sel_a <= a;
        sel_b <= b;
        mode <= m;
        skip <= sk;
        settle();
    endtask
    // pull one resource low; only its pin may show a low level
    task automatic place(input int r, input int pin);
        @(posedge clk_sys_in);
        p_out <= ~(17'h1 << r);
        settle();
        chk(pad_o, ~(17'h1 << pin), "pin placement");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        failures = 0; samples_checked = 0; cycles = 0;
        rstn_in = 1'b0; sel_a = '0; sel_b = '0; mode = '0; skip = '0;
        in_mode = '1; out_mode = '1; latch = '1; p_out = '1; p_oe = '1;
        repeat (20) @(posedge clk_sys_in);
        #1;
        chk(rx_en, '1, "reset input mode");
        chk(owned | pad_oe, '0, "reset drive");
        @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        cfg(8'h3F, 8'h3F, 2'h2, 16'h0);
        chk(owned, '0, "owned while off");
        chk(pad_oe, '0, "driver while off");
        chk(p_in, '1, "peripheral input while off");
        $display("test disabled done");
        cfg(8'h03, 8'h43, 2'h2, 16'h0);
        chk(owned, 17'h001FF, "example one map");
        place(0, 4);
        place(2, 0);
        place(5, 3);
        place(11, 6);
        place(13, 8);
        cfg(8'h03, 8'h43, 2'h2, 16'h003D);
        chk(owned, 17'h00FF2, "skip map");
        place(0, 4);
        place(3, 6);
        place(5, 8);
        place(13, 11);
        $display("test placement done");
        for (int f = 0; f < 4; f++) begin
            cfg(8'h00, 8'h40 | f[7:0], 2'h2, 16'h0);
            chk(owned, (17'h1 << f) - 17'h1, "counter field");
        end
        cfg(8'h02, 8'h40, 2'h2, 16'h0);
        chk(owned, 17'h0000F, "spi four wire");
        cfg(8'h02, 8'h40, 2'h1, 16'h0);
        chk(owned, 17'h00007, "spi three wire");
        // miso pulls its pin low, mosi stops asking for a driver;
        // the mosi pin then floats, so its bits are masked below
        @(posedge clk_sys_in);
        p_out <= ~(17'h1 << RES_SPI_MISO);
        p_oe <= ~(17'h1 << RES_SPI_MOSI);
        repeat (4) @(posedge clk_sys_in);
        #1;
        chk(p_in | (17'h1 << RES_SPI_MOSI), ~(17'h1 << RES_SPI_MISO),
            "peripheral input");
        chk(rd | 17'h4, ~17'h2, "port read");
        chk(pad_oe, ~17'h4, "peripheral drive request");
        @(posedge clk_sys_in);
        p_oe <= '1;
        cfg(8'h3E, 8'h7B, 2'h2, 16'h0);
        chk(owned, 17'h07FFF, "full priority map");
        for (int r = 2; r < RES_N; r++) begin
            place(r, r - 2);
        end
        @(posedge clk_sys_in);
        p_out <= '1;
        settle();
        chk({14'h0, pad_oe[0], pad_oe[5:4]}, 17'h4, "smbus drive");
        chk({15'h0, pad_pu[5:4]}, 17'h3, "smbus pull-up");
        $display("test priority done");
        @(posedge clk_sys_in);
        in_mode <= 17'h1FFFB;
        out_mode <= '0;
        latch <= 17'h1FFF7;
        cfg(8'h00, 8'h40, 2'h0, 16'h0004);
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk({14'h0, rx_en[2], pad_pu[2], pad_oe[2]}, '0, "analog cell");
        chk({15'h0, pad_oe[3], pad_pu[3]}, 17'h2, "low drive");
        chk({15'h0, pad_pu[6], rd[6]}, 17'h3, "open drain pull");
        chk({15'h0, rd[2], rd[3]}, '0, "analog read");
        cfg(8'h00, 8'hC0, 2'h0, 16'h0004);
        chk(pad_pu, '0, "pull-up disable");
        @(posedge clk_sys_in);
        out_mode <= '1;
        cfg(8'h00, 8'h40, 2'h0, 16'h0004);
        chk({16'h0, pad_pu[6]}, '0, "push-pull pull-up");
        $display("test pin cell done");
        finish_test();
    end
endmodule // ppxb_crossbar_tb

// ### dv/ppxb_pad_model.sv
// partner: board pads seen by the crossbar, with pull-ups and float
module ppxb_pad_model
    import ppxb_pkg::*;
(
    input  wire logic                       clk_sys_in,
    input  wire logic [ppxb_pkg::PIN_N-1:0] pad_out,
    input  wire logic [ppxb_pkg::PIN_N-1:0] pad_oe_out,
    input  wire logic [ppxb_pkg::PIN_N-1:0] pad_pullup_out,
    output logic      [ppxb_pkg::PIN_N-1:0] pad_lvl_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // an undriven pad with no pull flips every cycle, never a safe level
    logic [PIN_N-1:0] float_q = '0;
    always @(posedge clk_sys_in) begin
        float_q <= ~float_q;
    end
    assign pad_lvl_out = (pad_oe_out & pad_out) |
                         (~pad_oe_out & pad_pullup_out) |
                         (~pad_oe_out & ~pad_pullup_out & float_q);
endmodule // ppxb_pad_model

// ### rtl/ppxb_crossbar.sv
// module: priority pin crossbar with per-pin io cell control
module ppxb_crossbar
    import ppxb_pkg::*;
(
    // clock and reset
    input  wire logic                        clk_sys_in,
    input  wire logic                        rstn_in,
    // route selection and spi mode
    input  wire logic [7:0]                  periph_route_select_a_in,
    input  wire logic [7:0]                  periph_route_select_b_in,
    input  wire logic [1:0]                  spi_slave_select_mode_in,
    // per-pin configuration
    input  wire logic [ppxb_pkg::PIN_N-1:0]  pin_input_mode_in,
    input  wire logic [ppxb_pkg::PIN_N-1:0]  pin_output_mode_in,
    input  wire logic [ppxb_pkg::XBAR_N-1:0] pin_skip_mask_in,
    input  wire logic [ppxb_pkg::PIN_N-1:0]  port_latch_in,
    // peripheral side
    input  wire logic [ppxb_pkg::RES_N-1:0]  periph_out_in,
    input  wire logic [ppxb_pkg::RES_N-1:0]  periph_oe_in,
    output logic      [ppxb_pkg::RES_N-1:0]  periph_in_out,
    // pad side
    input  wire logic [ppxb_pkg::PIN_N-1:0]  pad_in,
    output logic      [ppxb_pkg::PIN_N-1:0]  pad_out,
    output logic      [ppxb_pkg::PIN_N-1:0]  pad_oe_out,
    output logic      [ppxb_pkg::PIN_N-1:0]  pad_pullup_out,
    output logic      [ppxb_pkg::PIN_N-1:0]  pad_rx_en_out,
    // status
    output logic      [ppxb_pkg::PIN_N-1:0]  port_read_out,
    output logic      [ppxb_pkg::PIN_N-1:0]  pin_assigned_out
);
    import ppxb_pkg::*;

    // ****************************************
    // pad synchroniser
    // ****************************************
    logic [PIN_N-1:0] pad_meta_q;           // first stage, read by second only
    logic [PIN_N-1:0] pad_sync_q;           // safe pad level

    // pads are asynchronous to the core clock
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            pad_meta_q <= '0;
            pad_sync_q <= '0;
        end else begin
            pad_meta_q <= pad_in;
            pad_sync_q <= pad_meta_q;
        end
    end

    // ****************************************
    // control field decode
    // ****************************************
    wire xbar_en;                           // global crossbar enable
    wire wpud;                              // global weak pull-up disable
    wire [1:0] pca_sel;                     // counter-array route field
    wire spi_4wire;                         // nss pinned out

    assign xbar_en   = periph_route_select_b_in[SELB_XBAR_EN];
    assign wpud      = periph_route_select_b_in[SELB_WPUD];
    assign pca_sel   = periph_route_select_b_in[SELB_PCA_LO +: 2];
    assign spi_4wire = spi_slave_select_mode_in[NSS_4WIRE_BIT];

    // ****************************************
    // per-resource request vector
    // ****************************************
    logic [RES_N-1:0] res_en;               // resources asking for a pin

    wire uart_sel = periph_route_select_a_in[SELA_UART];
    wire spi_sel  = periph_route_select_a_in[SELA_SPI];
    wire smb_sel  = periph_route_select_a_in[SELA_SMB];

    // uart and smbus always claim their signal pairs together
    assign res_en[RES_UART_TX]   = uart_sel;
    assign res_en[RES_UART_RX]   = uart_sel;
    assign res_en[RES_SPI_SCK]   = spi_sel;
    assign res_en[RES_SPI_MISO]  = spi_sel;
    assign res_en[RES_SPI_MOSI]  = spi_sel;
    assign res_en[RES_SPI_NSS]   = spi_sel & spi_4wire;
    assign res_en[RES_SMB_SDA]   = smb_sel;
    assign res_en[RES_SMB_SCL]   = smb_sel;
    assign res_en[RES_CMP_SYNC]  = periph_route_select_a_in[SELA_CMP];
    assign res_en[RES_CMP_ASYNC] = periph_route_select_a_in[SELA_CMPA];
    assign res_en[RES_SYSTEM_CLOCK_OUT]    = periph_route_select_a_in[SELA_SYSTEM_CLOCK_OUT];
    // counter-array outputs open up one at a time
    assign res_en[RES_COUNTER_ARRAY_OUT0] = (pca_sel != PCA_NONE);
    assign res_en[RES_COUNTER_ARRAY_OUT1] = (pca_sel == PCA_TWO) |
                              (pca_sel == PCA_THREE);
    assign res_en[RES_COUNTER_ARRAY_OUT2] = (pca_sel == PCA_THREE);
    assign res_en[RES_ECI]  = periph_route_select_b_in[SELB_ECI];
    assign res_en[RES_T0]   = periph_route_select_b_in[SELB_T0];
    assign res_en[RES_T1]   = periph_route_select_b_in[SELB_T1];

    // ****************************************
    // priority placement
    // ****************************************
    // walks resources in index order, which is the priority order;
    // purely combinational, so a whole chain of 15 searches settles
    // in one cycle at this slow core clock
    function automatic ppxb_map_t place_resources(
        input logic [RES_N-1:0]  en,
        input logic [XBAR_N-1:0] skip
    );
        ppxb_map_t         m;
        logic [XBAR_N-1:0] taken;
        logic              done;
        m     = '0;
        taken = skip;
        done  = 1'b0;
        // uart ignores skips, it owns its bootload pins
        if (en[RES_UART_TX]) begin
            m[UART_TX_PIN] = {1'b1, RES_W'(RES_UART_TX)};
            m[UART_RX_PIN] = {1'b1, RES_W'(RES_UART_RX)};
            taken[UART_TX_PIN] = 1'b1;
            taken[UART_RX_PIN] = 1'b1;
        end
        // only P0.0..P1.7 searched, P2.0 stays gpio
        for (int r = RES_SPI_SCK; r < RES_N; r++) begin
            done = 1'b0;
            if (en[r]) begin
                for (int p = 0; p < XBAR_N; p++) begin
                    if (!done && !taken[p]) begin
                        m[p]     = {1'b1, RES_W'(r)};
                        taken[p] = 1'b1;
                        done     = 1'b1;
                    end
                end
            end
        end
        return m;
    endfunction

    ppxb_map_t pin_map;                     // resource owning each pin
    assign pin_map = place_resources(res_en, pin_skip_mask_in);

    // ****************************************
    // peripheral input gather
    // ****************************************
    // unrouted inputs read high, the idle level of every serial line
    function automatic logic [RES_N-1:0] gather_inputs(
        input ppxb_map_t        m,
        input logic [PIN_N-1:0] lvl,
        input logic [PIN_N-1:0] rx_ok
    );
        logic [RES_N-1:0] v;
        v = PERIPH_IN_RST;
        for (int p = 0; p < PIN_N; p++) begin
            if (m[p][RES_W] && rx_ok[p]) begin
                v[m[p][RES_W-1:0]] = lvl[p];
            end
        end
        return v;
    endfunction

    // ****************************************
    // per-pin io cell control
    // ****************************************
    logic [PIN_N-1:0] out_d;                // pad output level
    logic [PIN_N-1:0] oe_d;                 // pad driver enable
    logic [PIN_N-1:0] pu_d;                 // weak pull-up enable
    logic [PIN_N-1:0] rx_d;                 // digital receiver enable
    logic [PIN_N-1:0] rd_d;                 // port read value
    logic [PIN_N-1:0] asg_d;                // pin carries a resource
    logic [RES_N-1:0] pin_in_d;             // level back to peripherals

    for (genvar p = 0; p < PIN_N; p++) begin : g_pin
        wire [RES_W-1:0] res;               // owning resource
        wire owned;                         // crossbar drives this pin
        wire digital;                       // input mode bit
        wire smb_pin;                       // smbus line forces od
        wire open_drain;                    // effective driver type
        wire val;                           // level to present
        wire want_drive;                    // source asks to drive
        wire drive;                         // final driver enable

        assign res     = pin_map[p][RES_W-1:0];
        // assignments only take effect once enabled
        assign owned   = xbar_en & pin_map[p][RES_W];
        assign digital = pin_input_mode_in[p];
        assign smb_pin = owned &
                         ((res == RES_W'(RES_SMB_SDA)) |
                          (res == RES_W'(RES_SMB_SCL)));
        // output mode bit applies to peripheral pins too
        assign open_drain = ~pin_output_mode_in[p] | smb_pin;
        // leftover pins fall back to the port latch
        assign val        = owned ? periph_out_in[res]
                                  : port_latch_in[p];
        assign want_drive = owned ? periph_oe_in[res] : 1'b1;
        // disabled crossbar or analog pin: no driver at all;
        // open-drain only ever pulls low
        assign drive = xbar_en & digital & want_drive &
                       (~open_drain | ~val);

        assign out_d[p] = val;
        assign oe_d[p]  = drive;
        // pull-up on open-drain digital pins not pulled low
        assign pu_d[p]  = digital & ~wpud & open_drain &
                          ~(drive & ~val);
        assign rx_d[p]  = digital;
        // analog pins read back zero, receiver is off
        assign rd_d[p]  = digital & pad_sync_q[p];
        assign asg_d[p] = owned;
    end

    // peripherals see nothing while the crossbar is off
    assign pin_in_d = xbar_en ? gather_inputs(pin_map, pad_sync_q, rx_d)
                              : PERIPH_IN_RST;

    // ****************************************
    // output registers
    // ****************************************
    // reset leaves every driver off and every pin a digital input;
    // the enable bit itself is held outside and resets clear
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            pad_out          <= '0;
            pad_oe_out       <= '0;
            pad_pullup_out   <= '0;
            pad_rx_en_out    <= '1;
            port_read_out    <= '0;
            pin_assigned_out <= '0;
            periph_in_out    <= PERIPH_IN_RST;
        end else begin
            pad_out          <= out_d;
            pad_oe_out       <= oe_d;
            pad_pullup_out   <= pu_d;
            pad_rx_en_out    <= rx_d;
            port_read_out    <= rd_d;
            pin_assigned_out <= asg_d;
            periph_in_out    <= pin_in_d;
        end
    end

endmodule // ppxb_crossbar

// ### rtl/ppxb_pkg.sv
// package: constants and types for the priority pin crossbar
package ppxb_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int PIN_N  = 17;             // P0.0 .. P2.0
    localparam int XBAR_N = 16;             // P0.0 .. P1.7 only
    localparam int RES_N  = 17;             // routed signals
    localparam int RES_W  = 5;              // resource index width

    // ****************************************
    // resource indices, in priority order
    // ****************************************
    localparam int RES_UART_TX = 0;
    localparam int RES_UART_RX = 1;
    localparam int RES_SPI_SCK = 2;
    localparam int RES_SPI_MISO = 3;
    localparam int RES_SPI_MOSI = 4;
    localparam int RES_SPI_NSS = 5;
    localparam int RES_SMB_SDA = 6;
    localparam int RES_SMB_SCL = 7;
    localparam int RES_CMP_SYNC = 8;
    localparam int RES_CMP_ASYNC = 9;
    localparam int RES_SYSTEM_CLOCK_OUT = 10;
    localparam int RES_COUNTER_ARRAY_OUT0 = 11;
    localparam int RES_COUNTER_ARRAY_OUT1 = 12;
    localparam int RES_COUNTER_ARRAY_OUT2 = 13;
    localparam int RES_ECI = 14;
    localparam int RES_T0 = 15;
    localparam int RES_T1 = 16;

    // ****************************************
    // fixed uart pins
    // ****************************************
    localparam int UART_TX_PIN = 4;
    localparam int UART_RX_PIN = 5;

    // ****************************************
    // select a field positions
    // ****************************************
    localparam int SELA_UART = 0;
    localparam int SELA_SPI = 1;
    localparam int SELA_SMB = 2;
    localparam int SELA_SYSTEM_CLOCK_OUT = 3;
    localparam int SELA_CMP = 4;
    localparam int SELA_CMPA = 5;

    // ****************************************
    // select b field positions
    // ****************************************
    localparam int SELB_PCA_LO = 0;
    localparam int SELB_ECI = 3;
    localparam int SELB_T0 = 4;
    localparam int SELB_T1 = 5;
    localparam int SELB_XBAR_EN = 6;
    localparam int SELB_WPUD = 7;

    // ****************************************
    // field codes
    // ****************************************
    localparam logic [1:0] PCA_NONE = 2'h0;
    localparam logic [1:0] PCA_ONE = 2'h1;
    localparam logic [1:0] PCA_TWO = 2'h2;
    localparam logic [1:0] PCA_THREE = 2'h3;
    localparam int NSS_4WIRE_BIT = 1;       // mode 1x is 4-wire

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [RES_N-1:0] PERIPH_IN_RST = 17'h1FFFF;

    // per pin: bit 5 valid, bits 4:0 resource index
    typedef logic [PIN_N-1:0][RES_W:0] ppxb_map_t;

endpackage
